// ===== include/fpsx_consts.svh
// Constants of the floating-point status and exception unit
// Notes on behaviour
// - Status word is not cleared by reset; contents undefined until software writes it.
// - Top byte returns an 8-bit system identifier; writes to it are ignored.
// - Identifier top bit is one for hardware, zero for software-only systems.
// - Trap enables at bits 16..20: invalid, divzero, overflow, underflow, inexact.
// - Trapped exception takes a trap and leaves its sticky flag alone.
// - Sticky flags at bits 0..4 in the same order; bits 5..7 reserved.
// - A set sticky flag stays set until a status write clears it.
// - Control bit 8 set flushes denormal operands to zero.
// - Bit 9 set makes every precision conversion of a signalling NaN invalid.
// - Bit 10 set runs every instruction synchronously, holding the host busy.
// - Bit 11 set selects the four-word packed decimal layout.
// - Bit 12 set makes compare carry mean greater-or-equal or unordered.
// - Untrapped invalid operation delivers a quiet NaN.
// - Infinity subtraction, zero times infinity, 0/0, inf/inf, bad remainder, negative root are invalid.
// - Impossible integer conversion is invalid; overflow yields signed largest integer.
// - Operations on signalling NaNs are invalid except loads and moves that keep the precision.
// - Signalling compares are invalid when any operand is a NaN.
// - Zero divisor with finite nonzero dividend raises divzero; untrapped gives signed infinity.
// - Overflow when rounded result exceeds largest; untrapped gives infinity or largest finite.
// - Underflow trapped on tininess; untrapped needs tininess and loss, also inexact.
// - Inexact on inexact rounding or untrapped overflow/underflow; those traps beat inexact.
`ifndef FPSX_CONSTS_SVH
`define FPSX_CONSTS_SVH
`define FPSX_FP_SYSTEM_IDENTIFIER_HI 31
`define FPSX_FP_SYSTEM_IDENTIFIER_LO 24
`define FPSX_TEN_LO 16
`define FPSX_CTL_FLUSH 8
`define FPSX_CTL_STRICT 9
`define FPSX_CTL_SYNC 10
`define FPSX_CTL_WIDE 11
`define FPSX_CTL_ALTC 12
// Arbitrary identifier value
`define FPSX_FP_SYSTEM_IDENTIFIER_DEF 8'h5a
`define FPSX_EXC_INV 0
`define FPSX_EXC_DZ 1
`define FPSX_EXC_OF 2
`define FPSX_EXC_UF 3
`define FPSX_EXC_IX 4
`define FPSX_QNAN_D 64'h7ff8000000000000
`define FPSX_INF_D 64'h7ff0000000000000
`define FPSX_MAXF_D 64'h7fefffffffffffff
`define FPSX_INT_MAX 32'h7fffffff
`define FPSX_INT_MIN 32'h80000000
`endif

// ===== include/fpsx_pkg.sv
// Types of the floating-point status and exception unit
package fpsx_pkg;
  typedef logic [4:0] fpsx_exc_t;
  typedef enum logic [3:0] {
    FPSX_OP_ARITH = 4'h0,
    FPSX_OP_ADD = 4'h1,
    FPSX_OP_SUB = 4'h2,
    FPSX_OP_MUL = 4'h3,
    FPSX_OP_DIV = 4'h4,
    FPSX_OP_REM = 4'h5,
    FPSX_OP_SQRT = 4'h6,
    FPSX_OP_FIX = 4'h7,
    FPSX_OP_CONV = 4'h8,
    FPSX_OP_LOAD = 4'h9,
    FPSX_OP_MOVE = 4'ha,
    FPSX_OP_CMP = 4'hb,
    FPSX_OP_CMPE = 4'hc
  } fpsx_op_e;
  typedef enum logic [1:0] {
    FPSX_RND_NEAR = 2'h0,
    FPSX_RND_PINF = 2'h1,
    FPSX_RND_MINF = 2'h2,
    FPSX_RND_ZERO = 2'h3
  } fpsx_rnd_e;
  typedef enum logic [1:0] {
    FPSX_PR_S = 2'h0,
    FPSX_PR_D = 2'h1,
    FPSX_PR_E = 2'h2
  } fpsx_pr_e;
  // Operand class flags for one operand
  typedef struct packed {
    logic snan;
    logic qnan;
    logic inf;
    logic zero;
    logic denorm;
    logic neg;
  } fpsx_cls_s;
  // One instruction's facts as the arithmetic unit reports them
  typedef struct packed {
    fpsx_op_e op;
    fpsx_pr_e src_pr;
    fpsx_pr_e dst_pr;
    fpsx_rnd_e rnd;
    fpsx_cls_s a;
    fpsx_cls_s b;
    logic fix_ovf;
    logic res_neg;
    logic ovf;
    logic tiny;
    logic loss;
    logic inexact;
  } fpsx_instr_s;
  typedef enum logic [2:0] {
    FPSX_ST_IDLE = 3'b001,
    FPSX_ST_BUSY = 3'b010,
    FPSX_ST_DONE = 3'b100
  } fpsx_st_e;
endpackage : fpsx_pkg

// ===== hdl/fpsx_detect.sv
// Exception condition detection for one instruction
`timescale 1ns/1ps
`default_nettype none
`include "fpsx_consts.svh"
module fpsx_detect
  import fpsx_pkg::*;
(
  // Instruction facts and controls
  input wire fpsx_instr_s INSTR,
  input wire logic STRICT,
  input wire fpsx_exc_t TEN,
  // Raised conditions
  output var fpsx_exc_t EXC
);
  function automatic logic is_nan(input fpsx_cls_s c);
    is_nan = c.snan | c.qnan;
  endfunction : is_nan

  logic snan_any;
  logic snan_exempt;
  logic conv_snan;
  logic inv;
  logic uf;
  always_comb
  begin
    snan_any = INSTR.a.snan | INSTR.b.snan;
    snan_exempt = (INSTR.op == FPSX_OP_LOAD)
      | ((INSTR.op == FPSX_OP_MOVE) & (INSTR.src_pr == INSTR.dst_pr));
    // Without strict mode extended acts as an internal format
    conv_snan = STRICT | ((INSTR.src_pr != FPSX_PR_E) & (INSTR.dst_pr != FPSX_PR_E));
    inv = (snan_any & ~snan_exempt & ((INSTR.op != FPSX_OP_CONV) | conv_snan));
    inv = inv | (((INSTR.op == FPSX_OP_SUB) | (INSTR.op == FPSX_OP_ADD)) & INSTR.a.inf
      & INSTR.b.inf & ((INSTR.op == FPSX_OP_SUB) ^ (INSTR.a.neg ^ INSTR.b.neg)));
    inv = inv | ((INSTR.op == FPSX_OP_MUL)
      & ((INSTR.a.zero & INSTR.b.inf) | (INSTR.a.inf & INSTR.b.zero)));
    inv = inv | ((INSTR.op == FPSX_OP_DIV)
      & ((INSTR.a.zero & INSTR.b.zero) | (INSTR.a.inf & INSTR.b.inf)));
    inv = inv | ((INSTR.op == FPSX_OP_REM) & (INSTR.a.inf | INSTR.b.zero));
    inv = inv | ((INSTR.op == FPSX_OP_SQRT) & INSTR.a.neg & ~INSTR.a.zero
      & ~is_nan(INSTR.a));
    inv = inv | ((INSTR.op == FPSX_OP_FIX)
      & (INSTR.fix_ovf | INSTR.a.inf | is_nan(INSTR.a)));
    inv = inv | ((INSTR.op == FPSX_OP_CMPE) & (is_nan(INSTR.a) | is_nan(INSTR.b)));
    EXC = '0;
    EXC[`FPSX_EXC_INV] = inv;
    EXC[`FPSX_EXC_DZ] = (INSTR.op == FPSX_OP_DIV) & INSTR.b.zero & ~INSTR.a.zero
      & ~INSTR.a.inf & ~is_nan(INSTR.a);
    EXC[`FPSX_EXC_OF] = INSTR.ovf & ~inv;
    uf = TEN[`FPSX_EXC_UF] ? INSTR.tiny : (INSTR.tiny & INSTR.loss);
    EXC[`FPSX_EXC_UF] = uf & ~inv;
    EXC[`FPSX_EXC_IX] = ~inv & (INSTR.inexact
      | (INSTR.ovf & ~TEN[`FPSX_EXC_OF]) | (uf & ~TEN[`FPSX_EXC_UF]));
  end
endmodule : fpsx_detect
`default_nettype wire

// ===== hdl/fpsx_result.sv
// Untrapped default results for raised exceptions
`timescale 1ns/1ps
`default_nettype none
`include "fpsx_consts.svh"
module fpsx_result
  import fpsx_pkg::*;
(
  // Instruction and decided conditions
  input wire fpsx_instr_s INSTR,
  input wire fpsx_exc_t EXC,
  // Replacement result
  output logic SUBST,
  output logic [63:0] VALUE
);
  logic to_inf;
  always_comb
  begin
    SUBST = 1'b0;
    VALUE = '0;
    // Directed rounding away from the sign saturates at largest finite
    case (INSTR.rnd)
      FPSX_RND_NEAR: to_inf = 1'b1;
      FPSX_RND_PINF: to_inf = ~INSTR.res_neg;
      FPSX_RND_MINF: to_inf = INSTR.res_neg;
      default: to_inf = 1'b0;
    endcase
    if (EXC[`FPSX_EXC_INV])
    begin
      SUBST = 1'b1;
      if (INSTR.op == FPSX_OP_FIX && INSTR.fix_ovf)
        VALUE = {32'h0, INSTR.a.neg ? `FPSX_INT_MIN : `FPSX_INT_MAX};
      else
        VALUE = `FPSX_QNAN_D;
    end
    else if (EXC[`FPSX_EXC_DZ])
    begin
      SUBST = 1'b1;
      VALUE = `FPSX_INF_D | {INSTR.a.neg ^ INSTR.b.neg, 63'h0};
    end
    else if (EXC[`FPSX_EXC_OF])
    begin
      SUBST = 1'b1;
      VALUE = (to_inf ? `FPSX_INF_D : `FPSX_MAXF_D) | {INSTR.res_neg, 63'h0};
    end
    else if (INSTR.op == FPSX_OP_SQRT && INSTR.a.zero && INSTR.a.neg)
    begin
      SUBST = 1'b1;
      VALUE = {1'b1, 63'h0};
    end
  end
endmodule : fpsx_result
`default_nettype wire

// ===== hdl/fpsx_status_unit.sv
// Floating-point status word and exception decision unit
`timescale 1ns/1ps
`default_nettype none
`include "fpsx_consts.svh"
module fpsx_status_unit
  import fpsx_pkg::*;
#(
  // Identifier low bits, arbitrary value
  parameter logic [7:0] FP_SYSTEM_IDENTIFIER_VAL = `FPSX_FP_SYSTEM_IDENTIFIER_DEF,
  parameter logic HW_IMPL = 1'b1
)
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Status word access by instructions
  input wire logic STATUS_WRITE_INSTR,
  input wire logic [31:0] WDATA,
  output logic [31:0] FP_STATUS_WORD,
  // Instruction completion from the arithmetic unit
  input wire logic ISSUE,
  input wire logic DONE,
  input wire fpsx_instr_s INSTR,
  // Outcome to the host
  output logic TRAP,
  output var fpsx_exc_t TRAP_CAUSE,
  output logic SUBST,
  output logic [63:0] SUBST_VALUE,
  output logic HOST_BUSY,
  output logic CARRY,
  input wire logic CMP_GE,
  input wire logic CMP_UNORD,
  // Feature controls to the datapath
  output logic FLUSH_DENORM_ZERO,
  output logic WIDE_DECIMAL_FMT
);
  // Status fields; no reset by design
  fpsx_exc_t trap_en_r, trap_en_nxt;
  logic [4:0] ctl_r, ctl_nxt;
  fpsx_exc_t sticky_r, sticky_nxt;
  fpsx_st_e st_r, st_nxt;
  logic trap_r, trap_nxt;
  fpsx_exc_t cause_r, cause_nxt;
  logic subst_r, subst_nxt;
  logic [63:0] val_r, val_nxt;
  logic carry_r, carry_nxt;
  fpsx_exc_t exc;
  fpsx_exc_t trapped;
  logic sub_w;
  logic [63:0] val_w;
  logic [7:0] fp_system_identifier;

  fpsx_detect u_detect (
    .INSTR(INSTR),
    .STRICT(ctl_r[`FPSX_CTL_STRICT - `FPSX_CTL_FLUSH]),
    .TEN(trap_en_r),
    .EXC(exc)
  );

  fpsx_result u_result (
    .INSTR(INSTR),
    .EXC(exc),
    .SUBST(sub_w),
    .VALUE(val_w)
  );

  always_comb
  begin
    trap_en_nxt = trap_en_r;
    ctl_nxt = ctl_r;
    sticky_nxt = sticky_r;
    trapped = exc & trap_en_r;
    // Overflow and underflow traps suppress the inexact trap
    if (trapped[`FPSX_EXC_OF] | trapped[`FPSX_EXC_UF])
      trapped[`FPSX_EXC_IX] = 1'b0;
    if (STATUS_WRITE_INSTR)
    begin
      trap_en_nxt = WDATA[`FPSX_TEN_LO +: 5];
      ctl_nxt = WDATA[`FPSX_CTL_FLUSH +: 5];
      sticky_nxt = WDATA[4:0];
    end
    if (DONE)
      sticky_nxt = sticky_nxt | (exc & ~trap_en_r);
  end

  always_ff @(posedge CLK)
  begin
    trap_en_r <= trap_en_nxt;
    ctl_r <= ctl_nxt;
    sticky_r <= sticky_nxt;
  end

  always_comb
  begin
    st_nxt = st_r;
    trap_nxt = 1'b0;
    cause_nxt = cause_r;
    subst_nxt = 1'b0;
    val_nxt = val_r;
    carry_nxt = carry_r;
    case (st_r)
      FPSX_ST_IDLE:
        if (ISSUE && !DONE && ctl_r[`FPSX_CTL_SYNC - `FPSX_CTL_FLUSH])
          st_nxt = FPSX_ST_BUSY;
      FPSX_ST_BUSY:
        if (DONE)
          st_nxt = FPSX_ST_DONE;
      // A new issue right after completion must not be lost
      FPSX_ST_DONE:
        if (ISSUE && !DONE && ctl_r[`FPSX_CTL_SYNC - `FPSX_CTL_FLUSH])
          st_nxt = FPSX_ST_BUSY;
        else
          st_nxt = FPSX_ST_IDLE;
      default:
        st_nxt = FPSX_ST_IDLE;
    endcase
    if (DONE)
    begin
      trap_nxt = |trapped;
      cause_nxt = trapped;
      subst_nxt = sub_w & ~(|(exc & trap_en_r));
      val_nxt = val_w;
      if (INSTR.op == FPSX_OP_CMP || INSTR.op == FPSX_OP_CMPE)
        carry_nxt = CMP_GE | (ctl_r[`FPSX_CTL_ALTC - `FPSX_CTL_FLUSH] & CMP_UNORD);
    end
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      st_r <= FPSX_ST_IDLE;
      trap_r <= 1'b0;
      cause_r <= '0;
      subst_r <= 1'b0;
      val_r <= '0;
      carry_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      trap_r <= trap_nxt;
      cause_r <= cause_nxt;
      subst_r <= subst_nxt;
      val_r <= val_nxt;
      carry_r <= carry_nxt;
    end
  end

  always_comb
  begin
    fp_system_identifier = {HW_IMPL, FP_SYSTEM_IDENTIFIER_VAL[6:0]};
    FP_STATUS_WORD = {fp_system_identifier, 3'h0, trap_en_r, 3'h0, ctl_r, 3'h0, sticky_r};
  end

  assign HOST_BUSY = (st_r == FPSX_ST_BUSY)
    | (ISSUE & ctl_r[`FPSX_CTL_SYNC - `FPSX_CTL_FLUSH] & (st_r != FPSX_ST_BUSY));
  assign TRAP = trap_r;
  assign TRAP_CAUSE = cause_r;
  assign SUBST = subst_r;
  assign SUBST_VALUE = val_r;
  assign CARRY = carry_r;
  assign FLUSH_DENORM_ZERO = ctl_r[0];
  assign WIDE_DECIMAL_FMT = ctl_r[`FPSX_CTL_WIDE - `FPSX_CTL_FLUSH];
endmodule : fpsx_status_unit
`default_nettype wire

// ===== verif/fpsx_status_unit_sva.sv
// Assertion checker of the status unit
`timescale 1ns/1ps
`default_nettype none
module fpsx_status_unit_sva
  import fpsx_pkg::*;
#(
  // Arbitrary identifier value
  parameter logic [7:0] FP_SYSTEM_IDENTIFIER_VAL = 8'h5a,
  parameter logic HW_IMPL = 1'b1
)
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Status word
  input wire logic STATUS_WRITE_INSTR,
  input wire logic [31:0] WDATA,
  input wire logic [31:0] FP_STATUS_WORD,
  // Instruction and outcome
  input wire logic ISSUE,
  input wire logic DONE,
  input wire fpsx_instr_s INSTR,
  input wire logic SUBST,
  input wire logic [63:0] SUBST_VALUE,
  input wire logic HOST_BUSY,
  input wire logic CARRY,
  input wire logic CMP_GE,
  input wire logic CMP_UNORD,
  input wire logic FLUSH_DENORM_ZERO,
  input wire logic WIDE_DECIMAL_FMT
);
  logic [31:0] sw;
  logic init_r = 1'b0;
  assign sw = FP_STATUS_WORD;
  // Word is undefined until the first write
  always_ff @(posedge CLK)
    init_r <= init_r | STATUS_WRITE_INSTR;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  sequence s_cmp; DONE && (INSTR.op == FPSX_OP_CMP || INSTR.op == FPSX_OP_CMPE); endsequence
  sequence s_sync; ISSUE && sw[10] && !DONE; endsequence
  property p_fp_system_identifier; sw[31:24] == {HW_IMPL, FP_SYSTEM_IDENTIFIER_VAL[6:0]}; endproperty
  a_fp_system_identifier: assert property (p_fp_system_identifier) else $error("bad id");
  property p_wr; STATUS_WRITE_INSTR && !DONE |=> {sw[20:16], sw[12:8], sw[4:0]} ==
    $past({WDATA[20:16], WDATA[12:8], WDATA[4:0]}); endproperty
  a_wr: assert property (p_wr) else $error("bad write");
  property p_sticky; init_r && !STATUS_WRITE_INSTR |=>
    (sw[4:0] & $past(sw[4:0])) == $past(sw[4:0]); endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");
  property p_trapkeep; init_r && DONE && sw[20:16] == 5'h1f && !STATUS_WRITE_INSTR |=>
    sw[4:0] == $past(sw[4:0]); endproperty
  a_trapkeep: assert property (p_trapkeep) else $error("trapped flag set");
  property p_ctl; init_r |-> FLUSH_DENORM_ZERO == sw[8] && WIDE_DECIMAL_FMT == sw[11]; endproperty
  a_ctl: assert property (p_ctl) else $error("bad control");
  property p_carry; s_cmp |=> CARRY == $past(CMP_GE || sw[12] && CMP_UNORD); endproperty
  a_carry: assert property (p_carry) else $error("bad carry");
  property p_busy; s_sync |-> HOST_BUSY; endproperty
  a_busy: assert property (p_busy) else $error("not busy");
  property p_dz; DONE && INSTR.op == FPSX_OP_DIV && INSTR.b.zero && INSTR.a == '0 && !sw[17]
    |=> SUBST && sw[1] && SUBST_VALUE[62:0] == 63'h7ff0000000000000; endproperty
  a_dz: assert property (p_dz) else $error("bad divzero");
endmodule : fpsx_status_unit_sva
bind fpsx_status_unit fpsx_status_unit_sva #(.FP_SYSTEM_IDENTIFIER_VAL(FP_SYSTEM_IDENTIFIER_VAL), .HW_IMPL(HW_IMPL)) i_sva (
  .CLK(CLK), .RESETN(RESETN), .STATUS_WRITE_INSTR(STATUS_WRITE_INSTR), .WDATA(WDATA),
  .FP_STATUS_WORD(FP_STATUS_WORD), .ISSUE(ISSUE), .DONE(DONE), .INSTR(INSTR), .SUBST(SUBST),
  .SUBST_VALUE(SUBST_VALUE), .HOST_BUSY(HOST_BUSY), .CARRY(CARRY), .CMP_GE(CMP_GE),
  .CMP_UNORD(CMP_UNORD), .FLUSH_DENORM_ZERO(FLUSH_DENORM_ZERO),
  .WIDE_DECIMAL_FMT(WIDE_DECIMAL_FMT));
`default_nettype wire

// ===== verif/fpsx_host.sv
// Host core model issuing instructions
`timescale 1ns/1ps
`default_nettype none
module fpsx_host
  import fpsx_pkg::*;
(
  // Requests from the bench
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic GO,
  input wire logic [1:0] LAT,
  input wire fpsx_instr_s NEXT,
  // Instruction flow
  output logic ISSUE,
  output logic DONE,
  output var fpsx_instr_s INSTR
);
  logic [1:0] cnt_r;
  fpsx_instr_s hold_r;
  // Facts toggle outside completion so stale values never look valid
  always_ff @(posedge CLK or negedge RESETN)
    if (!RESETN)
      {ISSUE, DONE, cnt_r, INSTR, hold_r} <= '0;
    else
    begin
      ISSUE <= GO;
      DONE <= cnt_r == 2'h1;
      INSTR <= cnt_r == 2'h1 ? hold_r : ~INSTR;
      hold_r <= GO ? NEXT : hold_r;
      cnt_r <= GO ? LAT : cnt_r - {1'b0, cnt_r != 2'h0};
    end
endmodule : fpsx_host
`default_nettype wire

// ===== verif/fpsx_status_unit_tb.sv
// Testbench of the status unit
`timescale 1ns/1ps
`default_nettype none
`include "fpsx_consts.svh"
module fpsx_status_unit_tb;
  import fpsx_pkg::*;
  localparam logic [7:0] SID = 8'h5a; // Arbitrary identifier
  localparam logic [7:0] ID = {1'b1, SID[6:0]};
  logic clk = 1'b0, rstn = 1'b0, swi = 1'b0, go = 1'b0, ge = 1'b0, un = 1'b0;
  logic [1:0] lat = 2'h1;
  logic [31:0] wd = '0, sw;
  fpsx_instr_s nx = '0, ins;
  logic iss, dn, trap, subst, busy, carry, fl, wide, bsy;
  fpsx_exc_t cause;
  logic [63:0] sval;
  int bad_count = 0, compares = 0, cyc = 0, tn = 0;
  always #20 clk = ~clk;
  fpsx_host i_host (.CLK(clk), .RESETN(rstn), .GO(go), .LAT(lat), .NEXT(nx), .ISSUE(iss),
    .DONE(dn), .INSTR(ins));
  fpsx_status_unit #(.FP_SYSTEM_IDENTIFIER_VAL(SID), .HW_IMPL(1'b1)) i_dut (.CLK(clk), .RESETN(rstn),
    .STATUS_WRITE_INSTR(swi), .WDATA(wd), .FP_STATUS_WORD(sw), .ISSUE(iss), .DONE(dn),
    .INSTR(ins), .TRAP(trap), .TRAP_CAUSE(cause), .SUBST(subst), .SUBST_VALUE(sval),
    .HOST_BUSY(busy), .CARRY(carry), .CMP_GE(ge), .CMP_UNORD(un), .FLUSH_DENORM_ZERO(fl),
    .WIDE_DECIMAL_FMT(wide));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [31:0] d);
    @(posedge clk);
    swi <= 1'b1;
    wd <= d;
    @(posedge clk);
    swi <= 1'b0;
    #1;
  endtask : wr
  // f holds destination precision, rounding, integer overflow and the four result flags
  task automatic run(input fpsx_op_e op, input logic [5:0] a, input logic [5:0] b,
    input logic [8:0] f, input logic [1:0] c, input logic [1:0] l);
    @(posedge clk);
    nx <= {op, FPSX_PR_S, f[8:5], a, b, f[4], 1'b0, f[3:0]};
    {ge, un} <= c;
    lat <= l;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    do
    begin
      @(posedge clk);
      #1;
    end
    while (dn !== 1'b1);
    bsy = busy;
    @(posedge clk);
    #1;
  endtask : run
  task automatic fin();
    tn++;
    $display("test %0d done", tn);
  endtask : fin
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      bad_count++;
      complete_run();
    end
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    wr(32'hffffffff);
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk(sw, {ID, 24'h1f1f1f});
    chk({fl, wide}, 2'b11);
    fin();
    wr(32'h0);
    chk(sw, {ID, 24'h0});
    run(FPSX_OP_DIV, 6'h04, 6'h04, 9'h000, 2'h0, 2'h1);
    chk(sval, `FPSX_QNAN_D);
    chk({trap, subst, sw[4:0]}, 7'h21);
    run(FPSX_OP_DIV, 6'h00, 6'h04, 9'h000, 2'h0, 2'h3);
    chk({subst, sval[62:0]}, {1'b1, 63'h7ff0000000000000});
    chk(sw[4:0], 5'h03);
    run(FPSX_OP_MUL, 6'h00, 6'h00, 9'h069, 2'h0, 2'h1);
    chk(sval, `FPSX_MAXF_D);
    chk(sw[4:0], 5'h17);
    run(FPSX_OP_MUL, 6'h00, 6'h00, 9'h007, 2'h0, 2'h1);
    chk(sw[4:0], 5'h1f);
    fin();
    wr(32'h001f1400);
    run(FPSX_OP_MUL, 6'h00, 6'h00, 9'h009, 2'h0, 2'h3);
    chk({trap, cause, sw[4:0], bsy}, 12'h901);
    run(FPSX_OP_MUL, 6'h00, 6'h00, 9'h004, 2'h0, 2'h1);
    chk({trap, cause}, 6'h28);
    run(FPSX_OP_CMP, 6'h00, 6'h00, 9'h000, 2'h1, 2'h1);
    chk(carry, 1'b1);
    fin();
    wr(32'h0);
    run(FPSX_OP_CMPE, 6'h00, 6'h10, 9'h000, 2'h1, 2'h1);
    chk({carry, sw[4:0], bsy}, 7'h02);
    run(FPSX_OP_FIX, 6'h01, 6'h00, 9'h010, 2'h0, 2'h1);
    chk(sval[31:0], `FPSX_INT_MIN);
    wr(32'h0);
    run(FPSX_OP_CONV, 6'h20, 6'h00, 9'h100, 2'h0, 2'h1);
    chk(sw[4:0], 5'h00);
    wr(32'h00000200);
    run(FPSX_OP_CONV, 6'h20, 6'h00, 9'h100, 2'h0, 2'h1);
    chk(sw[4:0], 5'h01);
    fin();
    wr(32'h0);
    run(FPSX_OP_MOVE, 6'h20, 6'h00, 9'h000, 2'h0, 2'h1);
    chk(sw[4:0], 5'h00);
    run(FPSX_OP_ADD, 6'h08, 6'h08, 9'h000, 2'h0, 2'h1);
    chk({subst, sw[4:0]}, 6'h00);
    run(FPSX_OP_ADD, 6'h08, 6'h09, 9'h000, 2'h0, 2'h1);
    chk({subst, sw[4:0]}, 6'h21);
    run(FPSX_OP_SUB, 6'h09, 6'h09, 9'h000, 2'h0, 2'h1);
    chk(subst, 1'b1);
    run(FPSX_OP_SQRT, 6'h05, 6'h00, 9'h000, 2'h0, 2'h1);
    chk(sval, 64'h8000000000000000);
    chk({subst, sw[4:0]}, 6'h21);
    fin();
    complete_run();
  end
endmodule : fpsx_status_unit_tb
`default_nettype wire
